/* File: core/isar_top.sv */
// Two-wire slave address match and receive path with double buffer.
`timescale 1ns/1ns
module isar_top (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Control
  input  wire logic [isar_pkg::MODE_W-1:0] mode_sel,
  input  wire logic                        port_enable_bit,
  input  wire logic                        ovr_clr_stb,
  input  wire logic                        evt_clr_stb,
  // Own address write and receive buffer read
  input  wire logic                        addr_wr_stb,
  input  wire logic [isar_pkg::BYTE_W-1:0] addr_wr_data,
  input  wire logic                        buf_rd_stb,
  output logic [isar_pkg::BYTE_W-1:0]      own_address,
  output logic [isar_pkg::BYTE_W-1:0]      receive_buffer,
  // Status
  output logic                             buffer_full_flag,
  output logic                             receive_overrun_flag,
  output logic                             serial_event_flag,
  output logic                             update_address_flag,
  output logic                             read_write_bit,
  output logic                             data_address_bit,
  output logic                             start_seen_bit,
  output logic                             stop_seen_bit,
  // Bus lines, open drain
  input  wire logic                        scl_in,
  output logic                             scl_out,
  output logic                             scl_oe_n,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  // Master clock output
  output logic                             master_scl
);
  import isar_pkg::*;

  isar_state_t         state_reg, state_next;     // Receive machine
  isar_kind_t          kind_reg, kind_next;       // Byte being received
  logic [3:0]          bit_cnt_reg, bit_cnt_next; // Bits shifted so far
  logic [BYTE_W-1:0]   shift_register_reg;        // Incoming bits
  logic [BYTE_W-1:0]   receive_buffer_reg;        // Held byte for software
  logic [BYTE_W-1:0]   own_address_reg;           // Slave address or divider
  logic                ten_done_reg;              // Full 10-bit match made
  logic                ev_pend_reg;               // Event due at ninth fall
  logic                stretch_reg;               // Hold clock after ack
  logic                sda_oe_n_reg, sda_oe_n_next;
  logic                scl_oe_n_reg, scl_oe_n_next;
  logic                rw_reg, da_reg, start_reg, stop_reg;
  logic [DIV_W-1:0]    div_cnt_reg;               // Master half period count
  logic                master_scl_reg;

  // Line edges
  logic scl_q, scl_rise, scl_fall, sda_rise, sda_fall;

  isar_edge u_scl_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (scl_in),
    .sig_q   (scl_q),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  isar_edge u_sda_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (sda_in),
    .sig_q   (),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Mode decode
  wire slave_mode = (mode_sel == MODE_SLV7) || (mode_sel == MODE_SLV10);
  wire slave_on = port_enable_bit && slave_mode;
  wire ten_mode = (mode_sel == MODE_SLV10);
  wire master_on = port_enable_bit && (mode_sel == MODE_MSTR);

  // Start and stop: data moves while clock stays high
  wire start_det = slave_on && sda_fall && scl_q && scl_in;
  wire stop_det  = slave_on && sda_rise && scl_q && scl_in;

  // Eighth falling clock edge ends a byte
  wire byte_done = (state_reg == ST_RECV) && scl_fall && (bit_cnt_reg == BYTE_BITS)
                   && !start_det && !stop_det;
  wire ninth_fall = (state_reg == ST_ACK) && scl_fall && !start_det && !stop_det;

  // Address comparisons
  wire hi_match = (shift_register_reg[ADDR_HI_BIT:ADDR_LO_BIT]
                   == own_address_reg[ADDR_HI_BIT:ADDR_LO_BIT]);
  wire hdr_ok   = (shift_register_reg[ADDR_HI_BIT:HDR_LO_BIT] == TEN_BIT_HDR);
  wire lo_match = (shift_register_reg == own_address_reg);
  wire dir_rd   = shift_register_reg[DIR_BIT];

  // A fresh header must carry write; after a repeated start a read is fine
  wire addr1_ok = ten_mode ? (hdr_ok && hi_match && (ten_done_reg || !dir_rd))
                           : hi_match;
  wire addr_match = (kind_reg == KIND_DATA) ? 1'b1 :
                    (kind_reg == KIND_ADDR2) ? lo_match : addr1_ok;
  wire need_upd = ten_mode && ((kind_reg == KIND_ADDR2) ||
                 (kind_reg == KIND_ADDR1 && !ten_done_reg));

  // Received byte actions by full and overrun state
  wire take_byte = byte_done && addr_match;
  wire load_now  = take_byte && !buffer_full_flag;
  wire ack_now   = take_byte && !buffer_full_flag && !receive_overrun_flag;
  wire ovr_set   = take_byte && buffer_full_flag;
  wire ev_set    = ninth_fall && ev_pend_reg;
  wire upd_set   = take_byte && need_upd;
  wire upd_clr   = addr_wr_stb;

  // Sticky flags
  isar_flag u_full_flag (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set     (load_now),
    .clr     (buf_rd_stb),
    .flag_q  (buffer_full_flag)
  );

  isar_flag u_ov_flag (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set     (ovr_set),
    .clr     (ovr_clr_stb),
    .flag_q  (receive_overrun_flag)
  );

  isar_flag u_ev_flag (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set     (ev_set),
    .clr     (evt_clr_stb),
    .flag_q  (serial_event_flag)
  );

  isar_flag u_upd_flag (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set     (upd_set),
    .clr     (upd_clr),
    .flag_q  (update_address_flag)
  );

  // Next byte kind after an accepted byte
  wire isar_kind_t kind_after = (kind_reg == KIND_ADDR1 && ten_mode && !ten_done_reg) ?
                                KIND_ADDR2 : KIND_DATA;

  // Machine next state; stop and start override any byte in flight
  always_comb begin
    state_next = state_reg;
    if (!slave_on) begin
      state_next = ST_IDLE;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end else if (start_det) begin
      state_next = ST_RECV;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_next = ST_IDLE;
        ST_RECV: begin
          if (byte_done) begin
            state_next = take_byte ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (ninth_fall) begin
            // Read transfers are served by the transmit path, so step aside
            state_next = stretch_reg ? ST_HOLD : (rw_reg ? ST_SKIP : ST_RECV);
          end
        end
        ST_HOLD: begin
          if (addr_wr_stb) begin
            state_next = ST_RECV;
          end
        end
        ST_SKIP: state_next = ST_SKIP;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // Bit counter restarts at each start and outside the receive state
  assign bit_cnt_next = (start_det || state_reg != ST_RECV) ? 4'h0 :
                        (scl_rise && bit_cnt_reg != BYTE_BITS) ? bit_cnt_reg + 4'h1 :
                        bit_cnt_reg;
  assign kind_next = start_det ? KIND_ADDR1 : (take_byte ? kind_after : kind_reg);

  // Data line: only the ack slot pulls low in this path
  assign sda_oe_n_next = (!slave_on || start_det || stop_det) ? 1'b1 :
                         ack_now ? 1'b0 :
                         (ninth_fall ? 1'b1 : sda_oe_n_reg);
  // Clock line held low from the ninth fall of a 10-bit address byte until the address is rewritten
  assign scl_oe_n_next = (!slave_on || stop_det) ? 1'b1 :
                         (ninth_fall && stretch_reg) ? 1'b0 :
                         (state_reg == ST_HOLD && addr_wr_stb) ? 1'b1 :
                         scl_oe_n_reg;

  // Machine registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      kind_reg     <= KIND_ADDR1;
      bit_cnt_reg  <= 4'h0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      bit_cnt_reg  <= bit_cnt_next;
      sda_oe_n_reg <= sda_oe_n_next;
      scl_oe_n_reg <= scl_oe_n_next;
    end
  end

  // Shifter samples data on each rising clock, even while buffer is full
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_register_reg <= RX_BUF_RST;
    end else if (state_reg == ST_RECV && scl_rise) begin
      shift_register_reg <= {shift_register_reg[BYTE_W-2:0], sda_in};
    end
  end

  // Buffer load; a full buffer is left alone and the byte is dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      receive_buffer_reg <= RX_BUF_RST;
    end else if (load_now) begin
      receive_buffer_reg <= shift_register_reg;
    end
  end

  // Own address register, written by software
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      own_address_reg <= OWN_ADDR_RST;
    end else if (addr_wr_stb) begin
      own_address_reg <= addr_wr_data;
    end
  end

  // Per-byte bookkeeping for the ack slot
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_pend_reg <= 1'b0;
      stretch_reg <= 1'b0;
    end else if (take_byte) begin
      ev_pend_reg <= 1'b1;
      stretch_reg <= need_upd;
    end else if (ninth_fall || state_reg == ST_IDLE) begin
      ev_pend_reg <= 1'b0;
      stretch_reg <= 1'b0;
    end
  end

  // Ten-bit match memory lasts until stop so a repeated start needs only the header
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ten_done_reg <= 1'b0;
    end else if (!slave_on || stop_det) begin
      ten_done_reg <= 1'b0;
    end else if (take_byte && kind_reg == KIND_ADDR2) begin
      ten_done_reg <= 1'b1;
    end
  end

  // Direction and byte kind of the last accepted byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rw_reg <= 1'b0;
      da_reg <= 1'b0;
    end else if (take_byte) begin
      rw_reg <= (kind_reg == KIND_ADDR1) ? dir_rd : rw_reg;
      da_reg <= (kind_reg == KIND_DATA);
    end
  end

  // Start and stop indication, cleared while the port is off
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !port_enable_bit) begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else if (start_det) begin
      start_reg <= 1'b1;
      stop_reg  <= 1'b0;
    end else if (stop_det) begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b1;
    end
  end

  // Master clock: toggles every 2(addr+1) cycles, period 4(addr+1)
  wire [DIV_W-1:0] half_period = DIV_W'((MASTER_DIV_MUL / 2) * (int'(own_address_reg) + 1));
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !master_on) begin
      div_cnt_reg    <= '0;
      master_scl_reg <= 1'b1;
    // At or above the end point, so a smaller new address cannot run the count around
    end else if (div_cnt_reg >= half_period - DIV_W'(1)) begin
      div_cnt_reg    <= '0;
      master_scl_reg <= ~master_scl_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  // Outputs
  assign own_address      = own_address_reg;
  assign receive_buffer   = receive_buffer_reg;
  assign read_write_bit   = rw_reg;
  assign data_address_bit = da_reg;
  assign start_seen_bit   = start_reg;
  assign stop_seen_bit    = stop_reg;
  assign scl_out          = 1'b0;
  assign sda_out          = 1'b0;
  assign scl_oe_n         = scl_oe_n_reg;
  assign sda_oe_n         = sda_oe_n_reg;
  assign master_scl       = master_scl_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_released;
    sda_oe_n && scl_oe_n;
  endsequence
  sequence s_addr_free;
    scl_oe_n && !update_address_flag;
  endsequence

  off_release_a: assert property (!port_enable_bit |=> s_released)
    else $error("lines driven while port disabled");
  clean_ack_a: assert property (byte_done && addr_match && !buffer_full_flag
      && !receive_overrun_flag |=> !sda_oe_n && buffer_full_flag)
    else $error("clean match did not ack and fill");
  no_ack_a: assert property (byte_done && (buffer_full_flag || receive_overrun_flag)
      |=> sda_oe_n)
    else $error("ack given with full or overrun set");
  full_drop_a: assert property (byte_done && addr_match && buffer_full_flag
      |=> receive_overrun_flag && $stable(receive_buffer))
    else $error("full buffer not kept or overrun not set");
  ovr_load_a: assert property (byte_done && addr_match && !buffer_full_flag
      |=> receive_buffer == $past(shift_register_reg))
    else $error("buffer not loaded from shifter");
  event_ninth_a: assert property (ninth_fall && ev_pend_reg |=> serial_event_flag)
    else $error("event flag missing after ninth fall");
  read_clear_a: assert property (buf_rd_stb && !load_now |=> !buffer_full_flag)
    else $error("buffer read left full flag set");
  hold_scl_a: assert property (state_reg == ST_HOLD && !addr_wr_stb && slave_on
      && !stop_det |=> !scl_oe_n && update_address_flag)
    else $error("clock not held while update pending");
  release_a: assert property (state_reg == ST_HOLD && addr_wr_stb |=> s_addr_free)
    else $error("address write did not release clock");
  start_flag_a: assert property (start_det |=> start_seen_bit && !stop_seen_bit)
    else $error("start not reported");
  data_pin_a: assert property (!sda_oe_n |-> state_reg == ST_ACK)
    else $error("data driven outside ack slot");

endmodule

/* File: core/isar_pkg.sv */
// Shared constants and types for the two-wire slave address receiver.
package isar_pkg;

  // Mode field width and encodings
  localparam int unsigned MODE_W = 4;
  localparam logic [3:0] MODE_SLV7 = 4'h6;   // Slave, 7-bit address
  localparam logic [3:0] MODE_SLV10 = 4'h7;  // Slave, 10-bit address
  localparam logic [3:0] MODE_MSTR = 4'h8;   // Master, divided clock

  // Byte framing
  localparam int unsigned BYTE_W = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;   // Bits per byte before the ack slot
  localparam logic [4:0] TEN_BIT_HDR = 5'h1E; // Leading pattern of a 10-bit header byte

  // Field positions inside a received address byte
  localparam int unsigned ADDR_HI_BIT = 7;   // Top of compared address bits
  localparam int unsigned ADDR_LO_BIT = 1;   // Bottom of compared address bits
  localparam int unsigned DIR_BIT = 0;       // Direction bit, 1 means read
  localparam int unsigned HDR_LO_BIT = 3;    // Bottom of header pattern field

  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] RX_BUF_RST = 8'h00;

  // Master clock divider: period is this factor times (address + 1)
  localparam int unsigned MASTER_DIV_MUL = 4;
  localparam int unsigned DIV_W = 10;

  // Receive state machine, Gray coded along idle, receive, ack, hold
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h3,
    ST_HOLD = 3'h2,
    ST_SKIP = 3'h6
  } isar_state_t;

  // Which byte of the frame is being shifted in
  typedef enum logic [1:0] {
    KIND_ADDR1 = 2'h0,
    KIND_ADDR2 = 2'h1,
    KIND_DATA  = 2'h3
  } isar_kind_t;

endpackage

/* File: core/isar_edge.sv */
// Edge finder for a bus line sampled on the system clock.
`timescale 1ns/1ns
module isar_edge (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Line in
  input  wire logic sig_in,
  // Delayed level and edges
  output logic      sig_q,
  output logic      rise,
  output logic      fall
);
  import isar_pkg::*;

  logic prev_reg;  // Level seen on the previous edge

  // Lines idle high, so the history starts high to avoid a false rise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= sig_in;
    end
  end

  assign sig_q = prev_reg;
  assign rise  = sig_in & ~prev_reg;
  assign fall  = ~sig_in & prev_reg;

endmodule

/* File: core/isar_flag.sv */
// Sticky status flag where a set beats a clear in the same cycle.
`timescale 1ns/1ns
module isar_flag (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Set and clear strobes
  input  wire logic set,
  input  wire logic clr,
  // Flag state
  output logic      flag_q
);
  import isar_pkg::*;

  logic flag_reg;   // Stored flag
  logic flag_next;  // Next flag value

  // Set has priority so an event in the clearing cycle is kept
  assign flag_next = set ? 1'b1 : (clr ? 1'b0 : flag_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_q = flag_reg;

endmodule

/* File: test/isar_master_model.sv */
// Behavioural two-wire bus master that drives the slave under test.
`timescale 1ns/1ns
module isar_master_model (
  // Clock
  input  wire logic sys_clk,
  // Wire levels seen on the bus
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Pull-downs, high means pull the line low
  output logic      scl_pull,
  output logic      sda_pull
);
  // Lines released at start, so the pull-ups hold them high
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Hold a level four cycles, above the two-cycle minimum
  task automatic lvl();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // Release SCL, then wait out any stretching by the slave
  task automatic rise_scl();
    int n;
    scl_pull = 1'b0;
    n = 0;
    while (scl_line !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    lvl();
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_pull = 1'b0;
    lvl();
    rise_scl();
    sda_pull = 1'b1;
    lvl();
    scl_pull = 1'b1;
    lvl();
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_pull = 1'b1;
    lvl();
    rise_scl();
    sda_pull = 1'b0;
    lvl();
  endtask
  // One byte MSB first, then the ack slot with SDA released
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      lvl();
      rise_scl();
      scl_pull = 1'b1;
      lvl();
    end
    sda_pull = 1'b0;
    lvl();
    rise_scl();
    // Ack is a low SDA late in the ninth high phase
    ack = (sda_line === 1'b0);
    scl_pull = 1'b1;
    lvl();
  endtask
endmodule

/* File: test/isar_top_tb.sv */
// Self-checking bench for the two-wire slave receive path.
`timescale 1ns/1ns
module isar_top_tb;
  import isar_pkg::*;
  // Clock, reset and control
  logic       sys_clk, sys_rst, port_enable_bit, ovr_clr_stb, evt_clr_stb;
  logic [3:0] mode_sel;
  logic       addr_wr_stb, buf_rd_stb;
  logic [7:0] addr_wr_data, own_address, receive_buffer;
  // Status outputs
  logic       buffer_full_flag, receive_overrun_flag, serial_event_flag;
  logic       update_address_flag, read_write_bit, data_address_bit;
  logic       start_seen_bit, stop_seen_bit, master_scl;
  // Bus lines: pull-up wins unless some party pulls low
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, scl_pull, sda_pull;
  wire        scl_in = ~scl_pull & scl_oe_n;
  wire        sda_in = ~sda_pull & sda_oe_n;
  // Counters
  int         errors, compares, cyc, n;
  logic       a;

  isar_top i_isar_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_sel(mode_sel),
    .port_enable_bit(port_enable_bit), .ovr_clr_stb(ovr_clr_stb), .evt_clr_stb(evt_clr_stb),
    .addr_wr_stb(addr_wr_stb), .addr_wr_data(addr_wr_data), .buf_rd_stb(buf_rd_stb),
    .own_address(own_address), .receive_buffer(receive_buffer),
    .buffer_full_flag(buffer_full_flag), .receive_overrun_flag(receive_overrun_flag),
    .serial_event_flag(serial_event_flag), .update_address_flag(update_address_flag),
    .read_write_bit(read_write_bit), .data_address_bit(data_address_bit),
    .start_seen_bit(start_seen_bit), .stop_seen_bit(stop_seen_bit), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .master_scl(master_scl));

  isar_master_model i_isar_master_model (.sys_clk(sys_clk), .scl_line(scl_in),
    .sda_line(sda_in), .scl_pull(scl_pull), .sda_pull(sda_pull));

  // 100 ns period clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // Closing summary and verdict
  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Compare with case equality so unknowns never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Drivers move one small delay after the rising edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // One-cycle strobe, then a spare cycle so it lands before the next look
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic wr_addr(input logic [7:0] v);
    addr_wr_data = v;
    pulse(addr_wr_stb);
  endtask
  // Buffer read checks the data and that the full flag drops
  task automatic rd_buf(input logic [7:0] e);
    chk(receive_buffer, e);
    pulse(buf_rd_stb);
    chk(buffer_full_flag, 1'b0);
  endtask
  // Byte on the bus, then ack, buffer and flag expectations
  task automatic xfer(input logic [7:0] b, input logic ea, input logic [7:0] eb,
                      input logic ebf, input logic eov, input logic eev);
    i_isar_master_model.send(b, a);
    chk(a, ea);
    chk(receive_buffer, eb);
    chk(buffer_full_flag, ebf);
    chk(receive_overrun_flag, eov);
    chk(serial_event_flag, eev);
    chk(sda_oe_n, 1'b1);
  endtask
  // Main sequence
  initial begin
    {sys_rst, port_enable_bit, ovr_clr_stb, evt_clr_stb} = 4'h8;
    {addr_wr_stb, buf_rd_stb, addr_wr_data, mode_sel} = {2'b00, 8'h00, MODE_SLV7};
    repeat (6) tick();
    sys_rst = 1'b0;
    chk({buffer_full_flag, receive_overrun_flag, serial_event_flag}, 8'h00);
    chk({own_address ^ receive_buffer}, 8'h00);
    chk({scl_oe_n, sda_oe_n, master_scl}, 8'h07);
    // Disabled port ignores a matching frame
    wr_addr(8'hA0);
    i_isar_master_model.start();
    chk(start_seen_bit, 1'b0);
    xfer(8'hA0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
    i_isar_master_model.stop();
    port_enable_bit = 1'b1;
    tick();
    // Mismatch, then repeated start with a match
    i_isar_master_model.start();
    chk(start_seen_bit, 1'b1);
    xfer(8'hB0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
    i_isar_master_model.start();
    xfer(8'hA0, 1'b1, 8'hA0, 1'b1, 1'b0, 1'b1);
    chk({read_write_bit, data_address_bit, sda_out, scl_out}, 8'h00);
    pulse(evt_clr_stb);
    xfer(8'h3C, 1'b0, 8'hA0, 1'b1, 1'b1, 1'b1);
    pulse(evt_clr_stb);
    rd_buf(8'hA0);
    xfer(8'h5A, 1'b0, 8'h5A, 1'b1, 1'b1, 1'b1);
    chk(data_address_bit, 1'b1);
    pulse(evt_clr_stb);
    rd_buf(8'h5A);
    pulse(ovr_clr_stb);
    xfer(8'h81, 1'b1, 8'h81, 1'b1, 1'b0, 1'b1);
    i_isar_master_model.stop();
    chk({start_seen_bit, stop_seen_bit}, 8'h01);
    pulse(evt_clr_stb);
    rd_buf(8'h81);
    // Ten-bit address, header A9 A8 = 01
    mode_sel = MODE_SLV10;
    wr_addr({TEN_BIT_HDR, 2'b01, 1'b0});
    i_isar_master_model.start();
    xfer(8'hF2, 1'b1, 8'hF2, 1'b1, 1'b0, 1'b1);
    chk({update_address_flag, scl_oe_n}, 8'h02);
    pulse(evt_clr_stb);
    rd_buf(8'hF2);
    wr_addr(8'h34);
    chk({update_address_flag, scl_oe_n}, 8'h01);
    xfer(8'h34, 1'b1, 8'h34, 1'b1, 1'b0, 1'b1);
    chk(update_address_flag, 1'b1);
    pulse(evt_clr_stb);
    rd_buf(8'h34);
    wr_addr(8'hF2);
    xfer(8'h77, 1'b1, 8'h77, 1'b1, 1'b0, 1'b1);
    pulse(evt_clr_stb);
    rd_buf(8'h77);
    // Repeated start: header alone matches, read direction
    i_isar_master_model.start();
    xfer(8'hF3, 1'b1, 8'hF3, 1'b1, 1'b0, 1'b1);
    chk({read_write_bit, update_address_flag, scl_oe_n}, 8'h05);
    i_isar_master_model.stop();
    // Master clock: half period is 2 * (address + 1) cycles
    mode_sel = MODE_MSTR;
    for (int k = 1; k < 3; k++) begin
      wr_addr(k[7:0]);
      repeat (2) begin
        a = master_scl;
        n = 0;
        while (master_scl === a && n < 100) begin
          tick();
          n++;
        end
      end
      chk(n[7:0], 8'(2 * (k + 1)));
    end
    report_and_stop();
  end
endmodule
